// ### logic/fsiw_params.svh
/*
  Constants of the fail-safe impact and watchdog window register block.
  Assumes a 100 MHz ref_clk and 16-bit serial frames, most significant bit first.
*/
`ifndef FSIW_PARAMS_SVH
`define FSIW_PARAMS_SVH

`define FSIW_FRAME_BITS    5'h10
`define FSIW_ADDR_TAKEN    5'h07
`define FSIW_CNT_MAX       5'h1f
`define FSIW_ADDR_IMPACT   6'h26
`define FSIW_ADDR_WINDOW   6'h27
`define FSIW_BIT_WRITE     15
`define FSIW_BIT_PARITY    8
`define FSIW_IMPACT_RST    4'h1
`define FSIW_WINDOW_RST    4'h3
`define FSIW_WINDOW_OFF    4'h0
`define FSIW_CLK_HZ        100000000
`define FSIW_DEEP_TIME_MS  8000
`define FSIW_DEEP_CYCLES   (`FSIW_DEEP_TIME_MS * (`FSIW_CLK_HZ / 1000))
`define FSIW_ERR_SAFETY    3
`define FSIW_ERR_CLOCK     2
`define FSIW_ERR_REQUEST   1
`define FSIW_ERR_PARITY    0

`endif

// ### logic/fsiw_pkg.sv
/*
  Types shared by the serial receiver and the register block.
  Assumes fsiw_params.svh holds the frame, register, error and timing numbers; the enum codes and window length table are below.
*/
package fsiw_pkg;

  typedef enum logic {
    FSIW_IDLE = 1'b0,
    FSIW_BUSY = 1'b1
  } fsiw_link_e;

  typedef enum logic [1:0] {
    FSIW_WD_NONE = 2'b00,
    FSIW_WD_RST  = 2'b01,
    FSIW_WD_FS0  = 2'b10,
    FSIW_WD_BOTH = 2'b11
  } fsiw_conseq_e;

  typedef logic [10:0] fsiw_ms_t;

  // Window length in milliseconds for each window code; zero means disabled.
  function automatic fsiw_ms_t fsiw_window_ms(input logic [3:0] code);
    fsiw_ms_t tbl [16];
    tbl = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h006, 11'h008, 11'h00c,
            11'h010, 11'h018, 11'h020, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400};
    return tbl[code];
  endfunction

endpackage

// ### logic/fsiw_frame_if.sv
/*
  Carrier between the serial receiver and the register block.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ns
interface fsiw_frame_if;
  logic        addr_stb;
  logic [5:0]  addr;
  logic [7:0]  load_byte;
  logic        done_stb;
  logic [15:0] frame;
  logic        clk_ok;

  modport rx   (output addr_stb, output addr, output done_stb, output frame, output clk_ok, input load_byte);
  modport regs (input addr_stb, input addr, input done_stb, input frame, input clk_ok, output load_byte);
endinterface

// ### logic/fsiw_spi_rx.sv
/*
  Serial frame receiver: synchronises the pins, shifts frames in and answers out.
  Assumes SPI mode 0 with each clock half period of at least five ref_clk cycles.
*/
`timescale 1ns/1ns
`include "fsiw_params.svh"
module fsiw_spi_rx (
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  input  wire logic     clk_en,
  input  wire logic     sclk,
  input  wire logic     cs_n,
  input  wire logic     mosi,
  input  wire logic [7:0] global_status,
  output logic          miso_out,
  output logic          miso_oe_n,
  fsiw_frame_if.rx      bus
);
  import fsiw_pkg::*;

  typedef struct packed {
    logic [2:0]  s_cs;
    logic [2:0]  s_sclk;
    logic [2:0]  s_mosi;
    logic [2:0]  filt;
    fsiw_link_e  link;
    logic [15:0] sin;
    logic [15:0] sout;
    logic [4:0]  cnt;
    logic        addr_stb;
    logic        done_stb;
    logic [15:0] frame;
    logic        clk_ok;
  } fsiw_rx_s;

  fsiw_rx_s st_r;
  fsiw_rx_s st_nxt;
  logic [2:0] second;
  logic [2:0] third;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt        = st_r;
    st_nxt.s_cs   = {st_r.s_cs[1:0], cs_n};
    st_nxt.s_sclk = {st_r.s_sclk[1:0], sclk};
    st_nxt.s_mosi = {st_r.s_mosi[1:0], mosi};
    second        = {st_r.s_cs[1], st_r.s_sclk[1], st_r.s_mosi[1]};
    third         = {st_r.s_cs[2], st_r.s_sclk[2], st_r.s_mosi[2]};
    for (int i = 0; i < 3; i++) begin
      if (second[i] == third[i]) begin
        st_nxt.filt[i] = second[i];
      end
    end
    st_nxt.addr_stb = 1'b0;
    st_nxt.done_stb = 1'b0;
    unique case (st_r.link)
      FSIW_IDLE: begin
        if (!st_nxt.filt[2]) begin
          st_nxt.link = FSIW_BUSY;
          st_nxt.cnt  = 5'h00;
          st_nxt.sout = {global_status, 8'h00};
        end
      end
      FSIW_BUSY: begin
        if (st_r.addr_stb) begin
          st_nxt.sout[13:6] = bus.load_byte;
        end
        if (st_nxt.filt[2]) begin
          st_nxt.link     = FSIW_IDLE;
          st_nxt.done_stb = 1'b1;
          st_nxt.frame    = st_r.sin;
          st_nxt.clk_ok   = (st_r.cnt == `FSIW_FRAME_BITS);
        end else if (st_nxt.filt[1] && !st_r.filt[1]) begin
          st_nxt.sin = {st_r.sin[14:0], st_r.filt[0]};
          if (st_r.cnt != `FSIW_CNT_MAX) begin
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
          st_nxt.addr_stb = (st_r.cnt == `FSIW_ADDR_TAKEN - 5'h01);
        end else if (!st_nxt.filt[1] && st_r.filt[1]) begin
          st_nxt.sout = {st_r.sout[14:0], 1'b0};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{s_cs: 3'h7, s_sclk: 3'h0, s_mosi: 3'h0, filt: 3'h4, link: FSIW_IDLE, sin: 16'h0000,
                sout: 16'h0000, cnt: 5'h00, addr_stb: 1'b0, done_stb: 1'b0, frame: 16'h0000, clk_ok: 1'b0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign miso_out     = st_r.sout[15];
  assign miso_oe_n    = (st_r.link == FSIW_IDLE);
  assign bus.addr_stb = st_r.addr_stb;
  assign bus.addr     = st_r.sin[5:0];
  assign bus.done_stb = st_r.done_stb;
  assign bus.frame    = st_r.frame;
  assign bus.clk_ok   = st_r.clk_ok;

endmodule // fsiw_spi_rx

// ### logic/fsiw_regs.sv
/*
  Fail-safe impact and watchdog window configuration registers behind a serial port.
  Assumes an external master sends 16-bit frames and watchdog logic flags the error limit.
*/
`timescale 1ns/1ns
`include "fsiw_params.svh"

// How it works
// - Impact write: write bit, address, parity, data.
// - Mode bit: zero delay, one duration.
// - Deep timer runs 8.0 s unless disabled.
// - Consequence field picks reset, fail-safe, both or neither to drive low.
// - Secure nibble must be the data nibble with its halves swapped and the low half inverted.
// - Window write: write bit, address, parity, code.
// - Window code picks duration; zero only init.
// - Write frames answer with previous content.
module fsiw_regs #(
  parameter int unsigned DEEP_CYCLES = `FSIW_DEEP_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             mosi,
  output logic                  miso_out,
  output logic                  miso_oe_n,
  input  wire logic [7:0]       global_status,
  input  wire logic             init_phase,
  input  wire logic             watchdog_error_limit,
  input  wire logic             failsafe_active,
  output logic                  reset_out_n,
  output logic                  first_failsafe_out,
  output logic                  fs2_timing_mode_sel,
  output logic                  deep_timer_disable,
  output logic                  deep_failsafe_req,
  output logic [3:0]            window_duration_code,
  output fsiw_pkg::fsiw_ms_t    window_ms
);
  import fsiw_pkg::*;

  typedef struct packed {
    logic [3:0]  impact;
    logic [3:0]  window;
    logic [3:0]  err;
    logic        rst_n_out;
    logic        fs0_n_out;
    logic [29:0] deep_cnt;
    logic        deep_req;
    fsiw_ms_t    win_ms;
  } fsiw_top_s;

  localparam logic [29:0] DEEP_LAST = 30'(DEEP_CYCLES - 1);

  fsiw_top_s  st_r;
  fsiw_top_s  st_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_s_n;
  logic       is_imp;
  logic       is_win;
  logic       par_ok;
  logic       sec_ok;
  logic       wr_ok_imp;
  logic       wr_ok_win;
  logic       win_bad;
  logic [3:0] err_set;
  fsiw_conseq_e conseq;

  fsiw_frame_if fr ();

  fsiw_spi_rx u_rx (
    .ref_clk       (ref_clk),
    .rst_n         (rst_s_n),
    .clk_en        (clk_en),
    .sclk          (sclk),
    .cs_n          (cs_n),
    .mosi          (mosi),
    .global_status (global_status),
    .miso_out      (miso_out),
    .miso_oe_n     (miso_oe_n),
    .bus           (fr.rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Answer byte taken at the address point, before any write lands.
  always_comb begin
    if (fr.addr == `FSIW_ADDR_IMPACT) begin
      fr.load_byte = {st_r.err, st_r.impact};
    end else if (fr.addr == `FSIW_ADDR_WINDOW) begin
      fr.load_byte = {st_r.err, st_r.window};
    end else begin
      fr.load_byte = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt  = st_r;
    conseq  = fsiw_conseq_e'(st_r.impact[1:0]);
    is_imp  = fr.frame[14:9] == `FSIW_ADDR_IMPACT;
    is_win  = fr.frame[14:9] == `FSIW_ADDR_WINDOW;
    par_ok  = ^fr.frame;
    sec_ok  = fr.frame[3:0] == {~fr.frame[5], ~fr.frame[4], fr.frame[7], fr.frame[6]};
    win_bad = is_win && fr.frame[7:4] == `FSIW_WINDOW_OFF && !init_phase;
    err_set = 4'h0;
    wr_ok_imp = 1'b0;
    wr_ok_win = 1'b0;
    if (fr.done_stb) begin
      if (!fr.clk_ok) begin
        err_set[`FSIW_ERR_CLOCK] = 1'b1;
      end else if (fr.frame[`FSIW_BIT_WRITE] && (is_imp || is_win)) begin
        err_set[`FSIW_ERR_PARITY]  = !par_ok;
        err_set[`FSIW_ERR_REQUEST] = par_ok && (!sec_ok || win_bad);
        wr_ok_imp = is_imp && par_ok && sec_ok;
        wr_ok_win = is_win && par_ok && sec_ok && !win_bad;
      end
    end
    err_set[`FSIW_ERR_SAFETY] = |err_set[2:0];
    if (wr_ok_imp) begin
      st_nxt.impact = fr.frame[7:4];
    end
    if (wr_ok_win) begin
      st_nxt.window = fr.frame[7:4];
    end
    // A read of either register clears the flags; a new error wins.
    if (fr.done_stb && fr.clk_ok && !fr.frame[`FSIW_BIT_WRITE] && (is_imp || is_win)) begin
      st_nxt.err = err_set;
    end else begin
      st_nxt.err = st_r.err | err_set;
    end
    st_nxt.rst_n_out = !(watchdog_error_limit && (conseq == FSIW_WD_RST || conseq == FSIW_WD_BOTH));
    st_nxt.fs0_n_out = !(watchdog_error_limit && (conseq == FSIW_WD_FS0 || conseq == FSIW_WD_BOTH));
    if (!failsafe_active || st_r.impact[2]) begin
      st_nxt.deep_cnt = 30'h00000000;
      st_nxt.deep_req = 1'b0;
    end else if (st_r.deep_cnt == DEEP_LAST) begin
      st_nxt.deep_req = 1'b1;
    end else begin
      st_nxt.deep_cnt = st_r.deep_cnt + 30'h00000001;
    end
    st_nxt.win_ms = fsiw_window_ms(st_r.window);
  end

  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_r <= '{impact: `FSIW_IMPACT_RST, window: `FSIW_WINDOW_RST, err: 4'h0, rst_n_out: 1'b1,
                fs0_n_out: 1'b1, deep_cnt: 30'h00000000, deep_req: 1'b0, win_ms: 11'h003};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign fs2_timing_mode_sel  = st_r.impact[3];
  assign deep_timer_disable   = st_r.impact[2];
  assign reset_out_n          = st_r.rst_n_out;
  assign first_failsafe_out   = st_r.fs0_n_out;
  assign deep_failsafe_req    = st_r.deep_req;
  assign window_duration_code = st_r.window;
  assign window_ms            = st_r.win_ms;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_s_n);

  a_impact_store: assert property (clk_en && wr_ok_imp |=> fs2_timing_mode_sel == $past(fr.frame[7])
      && deep_timer_disable == $past(fr.frame[6])) else $error("impact write not stored");
  a_mode_hold: assert property (clk_en && !wr_ok_imp |=> $stable(fs2_timing_mode_sel))
    else $error("timing mode changed without write");
  a_deep_off: assert property (clk_en && deep_timer_disable |=> !deep_failsafe_req)
    else $error("deep request while timer disabled");
  a_reset_low: assert property (clk_en && watchdog_error_limit && st_r.impact[0] |=> !reset_out_n)
    else $error("reset output not driven low");
  a_fs0_only: assert property (clk_en && watchdog_error_limit && st_r.impact[1:0] == 2'b10
      |=> !first_failsafe_out && reset_out_n) else $error("fail-safe only consequence wrong");
  a_secure_bad: assert property (clk_en && fr.done_stb && fr.clk_ok && fr.frame[15] && !sec_ok
      |=> $stable(st_r.impact) && $stable(window_duration_code)) else $error("bad secure bits accepted");
  a_window_store: assert property (clk_en && wr_ok_win |=> window_duration_code == $past(fr.frame[7:4]))
    else $error("window write not stored");
  a_status_byte: assert property (clk_en && fr.addr_stb && fr.addr == `FSIW_ADDR_WINDOW
      |=> u_rx.st_r.sout[13:6] == $past({st_r.err, st_r.window})) else $error("answer byte wrong");
  a_window_zero: assert property (clk_en && fr.done_stb && win_bad |=> $stable(window_duration_code))
    else $error("window zero accepted outside init");
  a_answer_prev: assert property (clk_en && fr.addr_stb && fr.addr == `FSIW_ADDR_IMPACT
      |=> u_rx.st_r.sout[9:6] == $past(st_r.impact)) else $error("answer not previous content");

  c_impact_write: cover property (wr_ok_imp);
  c_window_write: cover property (wr_ok_win);
  c_deep_req: cover property (!deep_failsafe_req ##1 deep_failsafe_req);
  c_both_low: cover property (!reset_out_n && !first_failsafe_out);

endmodule // fsiw_regs

// ### verif/fsiw_spi_master.sv
/*
  Serial master model that sends frames to the register block and collects its answer.
  Assumes SPI mode 0, paced by ref_clk, with a half period of at least six ref_clk cycles.
*/
`timescale 1ns/1ns
module fsiw_spi_master (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sends nbits of tx most significant bit first and samples the answer at each sclk rise.
  task automatic xfer(input logic [15:0] tx, input int nbits, input int half, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge ref_clk) cs_n <= 1'b0;
    repeat (half + 2) @(posedge ref_clk);
    for (int i = 15; i > 15 - nbits; i--) begin
      mosi <= tx[i];
      repeat (half) @(posedge ref_clk);
      rx[i] = (miso_oe_n === 1'b0) ? miso_out : 1'bx;
      sclk <= 1'b1;
      repeat (half) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge ref_clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule  // fsiw_spi_master

// ### verif/fsiw_regs_test.sv
/*
  Self-checking testbench of the impact and window register block.
  Assumes the serial master model and a 100 MHz ref_clk.
*/
`timescale 1ns/1ns
`include "fsiw_params.svh"
module fsiw_regs_test;
  logic        ref_clk;
  logic        rst_n;
  logic        clk_en;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso_out;
  logic        miso_oe_n;
  logic [7:0]  gstat;
  logic        init_phase;
  logic        wd_limit;
  logic        fs_active;
  logic        reset_out_n;
  logic        first_failsafe_out;
  logic        fs2_timing_mode_sel;
  logic        deep_timer_disable;
  logic        deep_failsafe_req;
  logic [3:0]  window_duration_code;
  logic [10:0] window_ms;
  logic [3:0]  prev;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [10:0] ms_tbl [16] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h006, 11'h008, 11'h00c,
                               11'h010, 11'h018, 11'h020, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400};

  fsiw_regs #(.DEEP_CYCLES(20)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .global_status(gstat), .init_phase(init_phase),
    .watchdog_error_limit(wd_limit), .failsafe_active(fs_active), .reset_out_n(reset_out_n),
    .first_failsafe_out(first_failsafe_out), .fs2_timing_mode_sel(fs2_timing_mode_sel),
    .deep_timer_disable(deep_timer_disable), .deep_failsafe_req(deep_failsafe_req),
    .window_duration_code(window_duration_code), .window_ms(window_ms));

  fsiw_spi_master master_u (
    .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n));

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h instead of %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [15:0] frame(input logic wr, input logic [5:0] a, input logic [3:0] d);
    logic [15:0] f;
    f = {wr, a, 1'b0, d, ~d[1], ~d[0], d[3], d[2]};
    if (wr)
      f[8] = ~^f;
    return f;
  endfunction

  // Sends one frame with a fresh status byte and compares the whole answer when all 16 bits are sent.
  task automatic sp(input logic [15:0] f, input logic [7:0] lo, input int n = 16);
    logic [15:0] rx;
    @(posedge ref_clk) gstat <= gstat + 8'h13;
    master_u.xfer(f, n, 6 + 3 * (n_checks % 2), rx);
    if (n == 16)
      check(rx, {gstat, lo});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and tests.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    wait_cyc(40000);
    num_errors++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    gstat = 8'h00;
    init_phase = 1'b0;
    wd_limit = 1'b0;
    fs_active = 1'b0;
    wait_cyc(16);
    rst_n <= 1'b1;
    wait_cyc(4);
    check(fs2_timing_mode_sel, 16'h0);
    check(deep_timer_disable, 16'h0);
    check(window_ms, 16'h3);
    check({reset_out_n, first_failsafe_out}, 16'h3);
    sp(frame(1'b0, `FSIW_ADDR_IMPACT, 4'h0), 8'h01);
    sp(frame(1'b0, `FSIW_ADDR_WINDOW, 4'h0), 8'h03);
    sp(frame(1'b1, `FSIW_ADDR_IMPACT, 4'hc), 8'h01);
    check(fs2_timing_mode_sel, 16'h1);
    check(deep_timer_disable, 16'h1);
    @(posedge ref_clk) fs_active <= 1'b1;
    wait_cyc(30);
    check(deep_failsafe_req, 16'h0);
    fs_active <= 1'b0;
    prev = 4'hc;
    for (int c = 0; c < 4; c++) begin
      sp(frame(1'b1, `FSIW_ADDR_IMPACT, c[3:0]), {4'h0, prev});
      prev = c[3:0];
      @(posedge ref_clk) wd_limit <= 1'b1;
      wait_cyc(3);
      check({reset_out_n, first_failsafe_out}, {14'h0, ~c[0], ~c[1]});
      wd_limit <= 1'b0;
      wait_cyc(3);
      check({reset_out_n, first_failsafe_out}, 16'h3);
    end
    check(fs2_timing_mode_sel, 16'h0);
    @(posedge ref_clk) fs_active <= 1'b1;
    wait_cyc(19);
    check(deep_failsafe_req, 16'h0);
    wait_cyc(2);
    check(deep_failsafe_req, 16'h1);
    fs_active <= 1'b0;
    prev = 4'h3;
    for (int c = 15; c >= 1; c--) begin
      sp(frame(1'b1, `FSIW_ADDR_WINDOW, c[3:0]), {4'h0, prev});
      prev = c[3:0];
      check(window_duration_code, c[15:0]);
      check(window_ms, {5'h00, ms_tbl[c]});
    end
    sp(frame(1'b1, `FSIW_ADDR_WINDOW, 4'h0), 8'h01);
    sp(frame(1'b0, `FSIW_ADDR_WINDOW, 4'h0), 8'ha1);
    sp(frame(1'b1, `FSIW_ADDR_WINDOW, 4'h5) ^ 16'h0100, 8'h01);
    sp(frame(1'b0, `FSIW_ADDR_WINDOW, 4'h0), 8'h91);
    sp(frame(1'b1, `FSIW_ADDR_WINDOW, 4'h5) ^ 16'h0003, 8'h01);
    sp(frame(1'b0, `FSIW_ADDR_WINDOW, 4'h0), 8'ha1);
    sp(frame(1'b1, `FSIW_ADDR_WINDOW, 4'h5), 8'h00, 15);
    sp(frame(1'b0, `FSIW_ADDR_WINDOW, 4'h0), 8'hc1);
    check(window_duration_code, 16'h1);
    sp(frame(1'b1, 6'h2a, 4'h5), 8'h00);
    @(posedge ref_clk) init_phase <= 1'b1;
    sp(frame(1'b1, `FSIW_ADDR_WINDOW, 4'h0), 8'h01);
    sp(frame(1'b0, `FSIW_ADDR_WINDOW, 4'h0), 8'h00);
    check(window_ms, 16'h0);
    // Clock enable low freezes the consequence outputs until it returns.
    @(posedge ref_clk) clk_en <= 1'b0;
    wd_limit <= 1'b1;
    wait_cyc(3);
    check({reset_out_n, first_failsafe_out}, 16'h3);
    clk_en <= 1'b1;
    wait_cyc(3);
    check({reset_out_n, first_failsafe_out}, 16'h0);
    wd_limit <= 1'b0;
    wait_cyc(3);
    check({reset_out_n, first_failsafe_out}, 16'h3);
    conclude();
  end
endmodule  // fsiw_regs_test
